// ===== common/ccbcs_pkg.sv
// constants, types and helpers shared by the cpu card bus cycle sequencer
// ============================================================
package ccbcs_pkg;

	// ============================================================
	// register map, byte addresses on the slave port
	localparam logic [4:0] REG_CTRL    = 5'h00;
	localparam logic [4:0] REG_PC      = 5'h04;
	localparam logic [4:0] REG_ACC     = 5'h08;
	localparam logic [4:0] REG_STATUS  = 5'h0c;
	localparam logic [4:0] REG_OPERAND = 5'h10;
	localparam int         CTRL_START_BIT = 0;
	localparam logic [15:0] PC_RESET  = 16'h0000;
	localparam logic [7:0]  ACC_RESET = 8'h00;

	// ============================================================
	// opcodes that open more machine cycles
	localparam logic [7:0] OP_STORE_ACC = 8'h32;
	localparam logic [7:0] OP_LOAD_ACC  = 8'h3a;
	localparam logic [7:0] OP_OUTPUT    = 8'hd3;
	localparam logic [7:0] OP_INPUT     = 8'hdb;

	// ============================================================
	// timing: each T state is two phase steps, six steps a cycle
	localparam logic [2:0] STEP_T1A = 3'h0;
	localparam logic [2:0] STEP_T1B = 3'h1;
	localparam logic [2:0] STEP_T2A = 3'h2;
	localparam logic [2:0] STEP_T2B = 3'h3;
	localparam logic [2:0] STEP_T3A = 3'h4;
	localparam logic [2:0] STEP_T3B = 3'h5;
	localparam logic [2:0] MC_1 = 3'h1;
	localparam logic [2:0] MC_2 = 3'h2;
	localparam logic [2:0] MC_3 = 3'h3;
	localparam logic [2:0] MC_4 = 3'h4;

	typedef enum logic [2:0] {
		KIND_FETCH, KIND_MREAD, KIND_DREAD, KIND_MEMORY_WRITE_STROBE, KIND_IN, KIND_OUT
	} ccbcs_kind_t;

	typedef enum logic {SEQ_IDLE, SEQ_RUN} ccbcs_seq_t;

	// status byte as it travels on the data lines in late T1
	typedef struct packed {
		logic memr;
		logic inp;
		logic m1;
		logic out;
		logic hlta;
		logic stack;
		logic wo_n;
		logic inta;
	} ccbcs_status_t;

	// software view of the sequencer state
	typedef struct packed {
		logic [18:0] zero;
		logic        missed;
		logic        busy;
		logic [2:0]  mcycle;
		logic [7:0]  opcode;
	} ccbcs_csr_status_t;

	// status byte belonging to each kind of machine cycle
	function automatic ccbcs_status_t ccbcs_status_for(input ccbcs_kind_t kind);
		ccbcs_status_t s;
		s = '0;
		s.wo_n = 1'b1;
		case (kind)
			KIND_FETCH: begin
				s.memr = 1'b1;
				s.m1 = 1'b1;
			end
			KIND_MREAD, KIND_DREAD: s.memr = 1'b1;
			KIND_MEMORY_WRITE_STROBE: s.wo_n = 1'b0;
			KIND_IN: s.inp = 1'b1;
			KIND_OUT: begin
				s.out = 1'b1;
				s.wo_n = 1'b0;
			end
			default: s = '0;
		endcase
		return s;
	endfunction : ccbcs_status_for

endpackage : ccbcs_pkg

// ===== core/ccbcs_sequencer.sv
// cpu card bus cycle sequencer: machine cycles on the backplane plus a register slave
`timescale 1ns/100ps
module ccbcs_sequencer
	import ccbcs_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          rst,
	input  wire logic          clk_en,
	input  wire logic [4:0]    avs_address,
	input  wire logic          avs_read,
	input  wire logic          avs_write,
	input  wire logic [31:0]   avs_writedata,
	input  wire logic [3:0]    avs_byteenable,
	output logic [31:0]        avs_readdata,
	output logic               avs_waitrequest,
	output logic [15:0]        addr_out,
	output ccbcs_status_t      status_data_o,
	output logic               status_data_oe,
	output logic               buffer_select_n,
	output logic               buffer_dir_in_n,
	output logic               bus_cycle_sync,
	output logic               status_strobe_n,
	output logic               input_cycle_status,
	output logic               output_cycle_status,
	output logic               memory_read_status,
	output logic               write_out_status_n,
	output logic               data_in_strobe,
	output logic               write_strobe_n,
	output logic               memory_write_strobe,
	output logic [7:0]         bus_data_out,
	output logic               bus_data_out_oe,
	input  wire logic [7:0]    bus_data_in,
	input  wire logic          panel_data_gate
);

	// ============================================================
	// declarations
	ccbcs_seq_t    state_reg, state_next;
	ccbcs_kind_t   kind_reg, kind_next, follow_kind;
	ccbcs_status_t stat_next;
	logic [2:0]    step_reg, step_next;
	logic [2:0]    mcycle_reg, mcycle_next;
	logic [15:0]   pc_reg;
	logic [7:0]    acc_reg;
	logic [7:0]    opcode_reg, lo_reg, hi_reg, capt_reg, op_sel;
	logic          missed_reg, start_reg, wait_reg;
	logic          cpu_read_window_reg;
	logic          cycle_end, finish, pc_step, is_read, is_write;
	logic          acc_load, wr_take, rd_take;
	logic [31:0]   rdata_mux;
	ccbcs_csr_status_t csr_stat;

	// ============================================================
	// slave handshake
	// waitrequest drops for exactly one cycle per request; the write lands
	// at the edge that ends that cycle, which is where the master samples it
	assign wr_take = avs_write && !wait_reg;
	assign rd_take = avs_read && !wait_reg;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wait_reg <= 1'b1;
			avs_readdata <= '0;
		end else if (clk_en) begin
			if ((avs_read || avs_write) && wait_reg) begin
				wait_reg <= 1'b0;
				avs_readdata <= rdata_mux;
			end else begin
				wait_reg <= 1'b1;
			end
		end
	end
	assign avs_waitrequest = wait_reg;

	// read mux, unmapped addresses read as zero
	always_comb begin
		csr_stat = '0;
		csr_stat.missed = missed_reg;
		csr_stat.busy = (state_reg == SEQ_RUN) || start_reg;
		csr_stat.mcycle = mcycle_reg;
		csr_stat.opcode = opcode_reg;
		case (avs_address)
			REG_CTRL: rdata_mux = {31'h00000000, start_reg};
			REG_PC: rdata_mux = {16'h0000, pc_reg};
			REG_ACC: rdata_mux = {24'h000000, acc_reg};
			REG_STATUS: rdata_mux = csr_stat;
			REG_OPERAND: rdata_mux = {16'h0000, hi_reg, lo_reg};
			default: rdata_mux = 32'h00000000;
		endcase
	end

	// start request waits for the sequencer, writes while busy are dropped
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			start_reg <= 1'b0;
		end else if (clk_en) begin
			if (state_reg == SEQ_IDLE && start_reg) begin
				start_reg <= 1'b0;
			end else if (wr_take && avs_address == REG_CTRL && avs_byteenable[0]
				&& state_reg == SEQ_IDLE) begin
				start_reg <= avs_writedata[CTRL_START_BIT];
			end
		end
	end

	// ============================================================
	// machine cycle sequencing
	assign cycle_end = (state_reg == SEQ_RUN) && (step_reg == STEP_T3B);
	assign op_sel = (mcycle_reg == MC_1) ? capt_reg : opcode_reg;

	// what follows the current cycle, and whether the counter steps
	always_comb begin
		follow_kind = KIND_FETCH;
		finish = 1'b1;
		pc_step = 1'b0;
		case (mcycle_reg)
			MC_1: begin
				pc_step = 1'b1;
				if (op_sel == OP_STORE_ACC || op_sel == OP_LOAD_ACC
					|| op_sel == OP_INPUT || op_sel == OP_OUTPUT) begin
					follow_kind = KIND_MREAD;
					finish = 1'b0;
				end
			end
			MC_2: begin
				finish = 1'b0;
				if (op_sel == OP_OUTPUT) begin
					follow_kind = KIND_OUT;
				end else if (op_sel == OP_INPUT) begin
					follow_kind = KIND_IN;
				end else begin
					follow_kind = KIND_MREAD;
					pc_step = 1'b1;
				end
			end
			MC_3: begin
				pc_step = 1'b1;
				// store ends in a memory write
				if (op_sel == OP_STORE_ACC) begin
					follow_kind = KIND_MEMORY_WRITE_STROBE;
					finish = 1'b0;
				// load ends in a read at fetched address
				end else if (op_sel == OP_LOAD_ACC) begin
					follow_kind = KIND_DREAD;
					finish = 1'b0;
				end
			end
			default: pc_step = 1'b0;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		step_next = step_reg;
		mcycle_next = mcycle_reg;
		kind_next = kind_reg;
		case (state_reg)
			SEQ_IDLE: begin
				if (start_reg) begin
					state_next = SEQ_RUN;
					step_next = STEP_T1A;
					mcycle_next = MC_1;
					kind_next = KIND_FETCH;
				end
			end
			SEQ_RUN: begin
				if (step_reg != STEP_T3B) begin
					step_next = step_reg + 3'h1;
				end else if (finish) begin
					state_next = SEQ_IDLE;
				end else begin
					step_next = STEP_T1A;
					mcycle_next = mcycle_reg + 3'h1;
					kind_next = follow_kind;
				end
			end
			default: state_next = SEQ_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= SEQ_IDLE;
			step_reg <= STEP_T1A;
			mcycle_reg <= MC_1;
			kind_reg <= KIND_FETCH;
		end else if (clk_en) begin
			state_reg <= state_next;
			step_reg <= step_next;
			mcycle_reg <= mcycle_next;
			kind_reg <= kind_next;
		end
	end

	// ============================================================
	// program counter; software may load it only while idle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pc_reg <= PC_RESET;
		end else if (clk_en) begin
			// counter steps only at chosen cycle ends
			if (cycle_end && pc_step) begin
				pc_reg <= pc_reg + 16'h0001;
			end else if (wr_take && avs_address == REG_PC && state_reg == SEQ_IDLE) begin
				if (avs_byteenable[0]) pc_reg[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1]) pc_reg[15:8] <= avs_writedata[15:8];
			end
		end
	end

	// ============================================================
	// operand bytes caught from the bus
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			capt_reg <= 8'h00;
			opcode_reg <= 8'h00;
			lo_reg <= 8'h00;
			hi_reg <= 8'h00;
			missed_reg <= 1'b0;
		end else if (clk_en) begin
			if (start_reg && state_reg == SEQ_IDLE) begin
				missed_reg <= 1'b0;
			end
			// byte taken only when strobe and gate agree
			if (step_reg == STEP_T3A && cpu_read_window_reg) begin
				if (panel_data_gate) begin
					capt_reg <= bus_data_in;
				end else begin
					missed_reg <= 1'b1;
				end
			end
			// low byte in M2, high byte in M3
			if (cycle_end) begin
				case (mcycle_reg)
					MC_1: opcode_reg <= capt_reg;
					MC_2: lo_reg <= capt_reg;
					MC_3: if (kind_reg == KIND_MREAD) hi_reg <= capt_reg;
					default: hi_reg <= hi_reg;
				endcase
			end
		end
	end

	// accumulator: filled by an input or load, else by software while idle
	assign acc_load = cycle_end && (kind_reg == KIND_IN || kind_reg == KIND_DREAD);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acc_reg <= ACC_RESET;
		end else if (clk_en) begin
			if (acc_load) begin
				acc_reg <= capt_reg;
			end else if (wr_take && avs_address == REG_ACC && avs_byteenable[0]
				&& state_reg == SEQ_IDLE) begin
				acc_reg <= avs_writedata[7:0];
			end
		end
	end

	// ============================================================
	// bus pins, decoded from the upcoming step so each flop is on time
	assign stat_next = ccbcs_status_for(kind_next);
	assign is_read = (kind_next == KIND_FETCH) || (kind_next == KIND_MREAD)
		|| (kind_next == KIND_DREAD) || (kind_next == KIND_IN);
	assign is_write = (kind_next == KIND_MEMORY_WRITE_STROBE) || (kind_next == KIND_OUT);

	// address, status and sync in late T1
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			addr_out <= 16'h0000;
			status_data_o <= '0;
			status_data_oe <= 1'b0;
			bus_cycle_sync <= 1'b0;
		end else if (clk_en) begin
			status_data_oe <= 1'b0;
			bus_cycle_sync <= 1'b0;
			if (state_next == SEQ_RUN && step_next == STEP_T1B) begin
				bus_cycle_sync <= 1'b1;
				status_data_oe <= 1'b1;
				status_data_o <= stat_next;
				case (kind_next)
					KIND_FETCH, KIND_MREAD: addr_out <= pc_reg;
					KIND_DREAD, KIND_MEMORY_WRITE_STROBE: addr_out <= {hi_reg, lo_reg};
					// device number repeated on both halves
					default: addr_out <= {lo_reg, lo_reg};
				endcase
			end
		end
	end

	// buffer controls: selected through a run, inward only in the window
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			buffer_select_n <= 1'b1;
			buffer_dir_in_n <= 1'b0;
			cpu_read_window_reg <= 1'b0;
		end else if (clk_en) begin
			buffer_select_n <= (state_next != SEQ_RUN);
			// window late T2 through early T3
			cpu_read_window_reg <= (state_next == SEQ_RUN) && is_read
				&& (step_next == STEP_T2B || step_next == STEP_T3A);
			buffer_dir_in_n <= (state_next == SEQ_RUN) && is_read
				&& (step_next == STEP_T2B || step_next == STEP_T3A);
		end
	end
	assign data_in_strobe = cpu_read_window_reg;

	// one-step strobe at T2 start, status held to cycle end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			status_strobe_n <= 1'b1;
			input_cycle_status <= 1'b0;
			output_cycle_status <= 1'b0;
			memory_read_status <= 1'b0;
			write_out_status_n <= 1'b1;
		end else if (clk_en) begin
			status_strobe_n <= !(state_next == SEQ_RUN && step_next == STEP_T2A);
			if (state_next != SEQ_RUN || step_next == STEP_T1A) begin
				// cleared between cycles so two types never overlap
				input_cycle_status <= 1'b0;
				output_cycle_status <= 1'b0;
				memory_read_status <= 1'b0;
				write_out_status_n <= 1'b1;
			end else if (step_next == STEP_T2A) begin
				input_cycle_status <= stat_next.inp;
				output_cycle_status <= stat_next.out;
				memory_read_status <= stat_next.memr;
				write_out_status_n <= stat_next.wo_n;
			end
		end
	end

	// data out in T3, strobe a step later once settled
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bus_data_out <= 8'h00;
			bus_data_out_oe <= 1'b0;
			write_strobe_n <= 1'b1;
			memory_write_strobe <= 1'b0;
		end else if (clk_en) begin
			bus_data_out_oe <= (state_next == SEQ_RUN) && is_write
				&& (step_next == STEP_T3A || step_next == STEP_T3B);
			if (state_next == SEQ_RUN && is_write && step_next == STEP_T3A) begin
				bus_data_out <= acc_reg;
			end
			write_strobe_n <= !((state_next == SEQ_RUN) && is_write
				&& step_next == STEP_T3B);
			// no memory strobe on output cycles
			memory_write_strobe <= (state_next == SEQ_RUN) && is_write
				&& step_next == STEP_T3B && !stat_next.out;
		end
	end

	// ============================================================
	// checks
	sync_to_strobe_a: assert property (
		@(posedge ref_clk) disable iff (rst || !clk_en)
		bus_cycle_sync |=> !status_strobe_n ##1 status_strobe_n)
		else $error("status strobe did not follow sync for one step");

	sync_spacing_a: assert property (
		@(posedge ref_clk) disable iff (rst || !clk_en)
		bus_cycle_sync |=> !bus_cycle_sync[*5])
		else $error("machine cycle shorter than three T states");

	status_out_a: assert property (
		@(posedge ref_clk) disable iff (rst || !clk_en)
		status_data_oe |-> (!buffer_select_n && !buffer_dir_in_n && bus_cycle_sync))
		else $error("status driven without outward buffers");

	io_addr_a: assert property (
		@(posedge ref_clk) disable iff (rst || !clk_en)
		(status_data_oe && (status_data_o.inp || status_data_o.out))
		|-> addr_out[15:8] == addr_out[7:0])
		else $error("device number not on both address halves");

	read_window_a: assert property (
		@(posedge ref_clk) disable iff (rst || !clk_en)
		$rose(data_in_strobe) |-> !$past(status_strobe_n)
		##0 (data_in_strobe && buffer_dir_in_n)[*2] ##1 !data_in_strobe)
		else $error("read window not two steps after the strobe");

	memory_write_strobe_gate_a: assert property (
		@(posedge ref_clk) disable iff (rst || !clk_en)
		memory_write_strobe |-> (!write_strobe_n && !output_cycle_status))
		else $error("memory write strobe outside a memory write");

	data_settled_a: assert property (
		@(posedge ref_clk) disable iff (rst || !clk_en)
		!write_strobe_n |-> (bus_data_out_oe && $past(bus_data_out_oe)
		&& !write_out_status_n))
		else $error("write strobe before data settled");

	one_type_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		$onehot0({input_cycle_status, output_cycle_status, memory_read_status}))
		else $error("more than one cycle type status");

	pc_hold_a: assert property (
		@(posedge ref_clk) disable iff (rst || !clk_en)
		(cycle_end && mcycle_reg == MC_2 && (opcode_reg == OP_INPUT
		|| opcode_reg == OP_OUTPUT)) |=> $stable(pc_reg))
		else $error("counter moved after device number read");

endmodule : ccbcs_sequencer

// ===== test/ccbcs_card_model.sv
// memory and i/o card model on the far side of the backplane
`timescale 1ns/100ps
module ccbcs_card_model
	import ccbcs_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [15:0] addr_out,
	input  wire logic        bus_cycle_sync,
	input  wire logic        input_cycle_status,
	input  wire logic        memory_read_status,
	input  wire logic        output_cycle_status,
	input  wire logic        data_in_strobe,
	input  wire logic        buffer_dir_in_n,
	input  wire logic        write_strobe_n,
	input  wire logic        memory_write_strobe,
	input  wire logic [7:0]  bus_data_out,
	input  wire logic        bus_data_out_oe,
	output logic [7:0]       bus_data_in,
	output logic [7:0]       out_dev,
	output logic [7:0]       out_data,
	output int               fault_cnt
);
	logic [7:0]  mem [0:255];
	logic [15:0] addr_reg;
	logic [7:0]  last_reg;
	int          faults = 0;

	// ============================================================
	// address and data paths
	// address decoded from the edge that sync marks it valid
	always @(posedge ref_clk) begin
		if (bus_cycle_sync === 1'b1) begin
			addr_reg <= addr_out;
		end
	end

	// drive only inside the read window; released lines toggle so stale data never matches
	assign bus_data_in = data_in_strobe ? (memory_read_status ? mem[addr_reg[7:0]]
		: addr_reg[7:0] ^ 8'ha5) : ~last_reg;

	// last value seen on the data-in lines
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			last_reg <= 8'h00;
		end else begin
			last_reg <= bus_data_in;
		end
	end

	// memory takes its strobe, the i/o card takes write strobe with output status
	always @(posedge ref_clk) begin
		if (memory_write_strobe === 1'b1) begin
			mem[addr_reg[7:0]] <= bus_data_out;
		end
		if (write_strobe_n === 1'b0 && output_cycle_status === 1'b1) begin
			out_dev  <= addr_reg[7:0];
			out_data <= bus_data_out;
		end
	end

	// wire faults a real card would suffer from
	always @(posedge ref_clk) begin
		if (!rst && data_in_strobe === 1'b1 && buffer_dir_in_n !== 1'b1) faults++;
		if (!rst && write_strobe_n === 1'b0 && bus_data_out_oe !== 1'b1) faults++;
		if (!rst && input_cycle_status === 1'b1 && addr_out[15:8] !== addr_out[7:0]) faults++;
	end
	assign fault_cnt = faults;

	// bench preloads program bytes here
	task automatic load(input logic [7:0] a, input logic [7:0] d);
		mem[a] = d;
	endtask : load
endmodule : ccbcs_card_model

// ===== test/ccbcs_sequencer_bench.sv
// self-checking bench for the cpu card bus cycle sequencer
`timescale 1ns/100ps
module ccbcs_sequencer_bench
	import ccbcs_pkg::*;
;
	logic          ref_clk = 1'b0;
	logic          rst = 1'b1;
	logic [4:0]    avs_address = 5'h00;
	logic          avs_read = 1'b0;
	logic          avs_write = 1'b0;
	logic [31:0]   avs_writedata = 32'h0;
	logic [31:0]   avs_readdata;
	logic          avs_waitrequest;
	logic [15:0]   addr_out;
	ccbcs_status_t status_data_o;
	logic          status_data_oe, buffer_select_n, buffer_dir_in_n, bus_cycle_sync;
	logic          status_strobe_n, input_cycle_status, output_cycle_status;
	logic          memory_read_status, write_out_status_n, data_in_strobe;
	logic          write_strobe_n, memory_write_strobe, bus_data_out_oe;
	logic [7:0]    bus_data_out, bus_data_in, out_dev, out_data;
	logic          panel_data_gate = 1'b1;
	int            fault_cnt;
	int            fails = 0;
	int            check_count = 0;
	int            cyc = 0;
	int            cnt [7] = '{default: 0};
	logic [6:0]    ev;

	ccbcs_sequencer u_ccbcs_sequencer (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .addr_out(addr_out), .status_data_o(status_data_o),
		.status_data_oe(status_data_oe), .buffer_select_n(buffer_select_n),
		.buffer_dir_in_n(buffer_dir_in_n), .bus_cycle_sync(bus_cycle_sync),
		.status_strobe_n(status_strobe_n), .input_cycle_status(input_cycle_status),
		.output_cycle_status(output_cycle_status), .memory_read_status(memory_read_status),
		.write_out_status_n(write_out_status_n), .data_in_strobe(data_in_strobe),
		.write_strobe_n(write_strobe_n), .memory_write_strobe(memory_write_strobe),
		.bus_data_out(bus_data_out), .bus_data_out_oe(bus_data_out_oe),
		.bus_data_in(bus_data_in), .panel_data_gate(panel_data_gate));

	ccbcs_card_model u_ccbcs_card_model (.ref_clk(ref_clk), .rst(rst), .addr_out(addr_out),
		.bus_cycle_sync(bus_cycle_sync), .input_cycle_status(input_cycle_status),
		.memory_read_status(memory_read_status), .output_cycle_status(output_cycle_status),
		.data_in_strobe(data_in_strobe), .buffer_dir_in_n(buffer_dir_in_n),
		.write_strobe_n(write_strobe_n), .memory_write_strobe(memory_write_strobe),
		.bus_data_out(bus_data_out), .bus_data_out_oe(bus_data_out_oe),
		.bus_data_in(bus_data_in), .out_dev(out_dev), .out_data(out_data),
		.fault_cnt(fault_cnt));

	// ============================================================
	// clock, event counts and watchdog
	always #12.5 ref_clk = ~ref_clk;

	// bus events counted per cycle so each instruction can be judged by its totals
	assign ev = {data_in_strobe, input_cycle_status, ~status_strobe_n, ~write_out_status_n,
		~write_strobe_n, memory_write_strobe, bus_cycle_sync};
	always @(posedge ref_clk) begin
		cyc++;
		for (int i = 0; i < 7; i++) cnt[i] += int'(ev[i]);
		chk(32'($countones({input_cycle_status, output_cycle_status, memory_read_status}) > 1),
			32'h0);
		if (cyc == 6000) begin
			fails++;
			close_out();
		end
	end

	// ============================================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one avalon transfer; request held until waitrequest is sampled low
	task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge ref_clk);
		avs_address   <= a;
		avs_read      <= ~wr;
		avs_write     <= wr;
		avs_writedata <= d;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : av

	// start one instruction, optionally poke acc while busy, wait and judge event totals
	task automatic run(input logic poke, input logic [6:0][7:0] e);
		int          base [7];
		logic [31:0] q;
		base = cnt;
		av(1'b1, REG_CTRL, 32'h1, q);
		if (poke) av(1'b1, REG_ACC, 32'hff, q);
		do av(1'b0, REG_STATUS, 32'h0, q); while (q[11] !== 1'b0);
		for (int i = 0; i < 7; i++) chk(32'(cnt[i] - base[i]), 32'(e[i]));
	endtask : run

	// read a register and compare it
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] q;
		av(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask : rd_chk

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out

	// ============================================================
	// scenarios
	task automatic scn_reset();
		chk(32'({avs_waitrequest, status_strobe_n, write_strobe_n, bus_cycle_sync}), 32'he);
		rd_chk(REG_PC, 32'(PC_RESET));
		rd_chk(REG_ACC, 32'(ACC_RESET));
		rd_chk(5'h14, 32'h0);
	endtask : scn_reset

	task automatic scn_store();
		logic [31:0] q;
		u_ccbcs_card_model.load(8'h00, OP_STORE_ACC);
		u_ccbcs_card_model.load(8'h01, 8'h40);
		u_ccbcs_card_model.load(8'h02, 8'h00);
		av(1'b1, REG_ACC, 32'h5a, q);
		run(1'b0, {8'd6, 8'd0, 8'd4, 8'd4, 8'd1, 8'd1, 8'd4});
		chk(32'(u_ccbcs_card_model.mem[8'h40]), 32'h5a);
		rd_chk(REG_PC, 32'h3);
	endtask : scn_store

	task automatic scn_load();
		u_ccbcs_card_model.load(8'h03, OP_LOAD_ACC);
		u_ccbcs_card_model.load(8'h04, 8'h41);
		u_ccbcs_card_model.load(8'h05, 8'h00);
		u_ccbcs_card_model.load(8'h41, 8'hc3);
		run(1'b0, {8'd8, 8'd0, 8'd4, 8'd0, 8'd0, 8'd0, 8'd4});
		rd_chk(REG_ACC, 32'hc3);
		rd_chk(REG_PC, 32'h6);
	endtask : scn_load

	task automatic scn_output();
		logic [31:0] q;
		u_ccbcs_card_model.load(8'h06, OP_OUTPUT);
		u_ccbcs_card_model.load(8'h07, 8'h07);
		av(1'b1, REG_ACC, 32'h3c, q);
		run(1'b1, {8'd4, 8'd0, 8'd3, 8'd4, 8'd1, 8'd0, 8'd3});
		chk(32'({out_dev, out_data}), 32'h073c);
		rd_chk(REG_PC, 32'h8);
	endtask : scn_output

	task automatic scn_input();
		u_ccbcs_card_model.load(8'h08, OP_INPUT);
		u_ccbcs_card_model.load(8'h09, 8'h09);
		run(1'b0, {8'd6, 8'd4, 8'd3, 8'd0, 8'd0, 8'd0, 8'd3});
		rd_chk(REG_ACC, 32'hac);
		rd_chk(REG_PC, 32'ha);
		rd_chk(REG_STATUS, 32'({MC_3, OP_INPUT}));
	endtask : scn_input

	// gate held low from the fetch on: the opcode never gets in, so the old
	// byte is decoded as a one-cycle instruction and nothing reaches the accumulator
	task automatic scn_missed();
		ccbcs_csr_status_t s;
		logic [31:0]       q;
		u_ccbcs_card_model.load(8'h0a, OP_INPUT);
		u_ccbcs_card_model.load(8'h0b, 8'h0b);
		panel_data_gate <= 1'b0;
		run(1'b0, {8'd2, 8'd0, 8'd1, 8'd0, 8'd0, 8'd0, 8'd1});
		panel_data_gate <= 1'b1;
		rd_chk(REG_ACC, 32'hac);
		av(1'b0, REG_STATUS, 32'h0, q);
		s = q;
		chk(32'(s.missed), 32'h1);
		chk(32'(s.opcode), 32'hac);
		rd_chk(REG_PC, 32'hb);
	endtask : scn_missed

	// ============================================================
	// main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		scn_reset();
		scn_store();
		scn_load();
		scn_output();
		scn_input();
		scn_missed();
		chk(32'(fault_cnt), 32'h0);
		close_out();
	end
endmodule : ccbcs_sequencer_bench
